/* File: ccdo_core.sv */
`timescale 1ns/1ps
`include "ccdo_cfg.svh"

module ccdo_core (
  // apb clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb request
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  // apb answer
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr
);

  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  function automatic logic addr_is(input logic [11:0] a, input logic [11:0] off);
    addr_is = (a == off);
  endfunction

  function automatic logic file_hit(input logic [11:0] a);
    file_hit = (a[11:9] == `CCDO_FILE_BASE_HI);
  endfunction

  function automatic logic is_call(input ccdo_pkg::ccdo_op_t o);
    is_call = (o == `CCDO_OP_CALL) || (o == `CCDO_OP_CALL_IND);
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [7:0]          file_mem [`CCDO_FILE_DEPTH];
  logic [14:0]         return_stack [`CCDO_STACK_DEPTH];
  logic [3:0]          stack_ptr;
  logic [14:0]         pc;
  logic [7:0]          wreg;
  logic [6:0]          program_page_latch;
  logic                zero_flag;
  logic                timeout_flag;
  logic                power_down_flag;
  logic [15:0]         watchdog_counter;
  logic [7:0]          watchdog_prescaler;
  ccdo_pkg::ccdo_state_e state;

  logic                busy;
  logic                access;
  logic                wr_en;
  logic                cmd_go;
  logic                mapped;
  ccdo_pkg::ccdo_op_t  op;
  logic                dest_file;
  logic [6:0]          f_addr;
  logic [10:0]         k_lit;
  logic [7:0]          f_val;
  logic [7:0]          f_dec;
  logic [7:0]          result;
  logic                res_to_file;
  logic                res_to_w;
  logic                upd_zero;
  logic                two_cycle;
  logic [14:0]         ret_addr;
  logic [31:0]         next_prdata;

  assign busy     = (state == ccdo_pkg::ccdo_second);
  assign pready   = ~busy;
  assign access   = psel & penable & pready;
  assign wr_en    = access & pwrite;
  assign cmd_go   = wr_en & addr_is(paddr, `CCDO_OFF_CMD);
  assign mapped   = file_hit(paddr) | addr_is(paddr, `CCDO_OFF_CMD)
                  | addr_is(paddr, `CCDO_OFF_WREG) | addr_is(paddr, `CCDO_OFF_PC)
                  | addr_is(paddr, `CCDO_OFF_PAGE) | addr_is(paddr, `CCDO_OFF_STATUS)
                  | addr_is(paddr, `CCDO_OFF_STACK) | addr_is(paddr, `CCDO_OFF_WDOG);
  assign pslverr  = psel & penable & ~mapped;

  assign op        = pwdata[`CCDO_CMD_OP_HI:0];
  assign dest_file = pwdata[`CCDO_CMD_DEST_BIT];
  assign f_addr    = pwdata[`CCDO_CMD_F_HI:`CCDO_CMD_F_LO];
  assign k_lit     = pwdata[`CCDO_CMD_K_HI:`CCDO_CMD_K_LO];
  assign f_val     = file_mem[f_addr];
  assign f_dec     = f_val - 8'h01;
  assign ret_addr  = pc + 15'h0001;

  // ----------------------------------------
  // operation decode
  // ----------------------------------------
  always_comb begin
    result      = 8'h00;
    res_to_file = 1'b0;
    res_to_w    = 1'b0;
    upd_zero    = 1'b0;
    two_cycle   = 1'b0;
    case (op)
      `CCDO_OP_CALL, `CCDO_OP_CALL_IND: begin
        two_cycle = 1'b1; // RULE2 RULE3
      end
      `CCDO_OP_COMP_FILE: begin
        result      = ~f_val; // RULE5
        res_to_file = dest_file;
        res_to_w    = ~dest_file;
        upd_zero    = 1'b1;
      end
      `CCDO_OP_CLR_FILE: begin
        result      = 8'h00; // RULE6
        res_to_file = 1'b1;
        upd_zero    = 1'b1;
      end
      `CCDO_OP_DEC_FILE: begin
        result      = f_dec; // RULE7
        res_to_file = dest_file;
        res_to_w    = ~dest_file;
        upd_zero    = 1'b1;
      end
      `CCDO_OP_CLR_W: begin
        result   = 8'h00; // RULE8
        res_to_w = 1'b1;
        upd_zero = 1'b1;
      end
      `CCDO_OP_DECSKIP: begin
        result      = f_dec; // RULE9
        res_to_file = dest_file;
        res_to_w    = ~dest_file;
        two_cycle   = (f_dec == 8'h00);
      end
      default: begin
        result = 8'h00;
      end
    endcase
  end

  // ----------------------------------------
  // instruction cycle sequencing
  // ----------------------------------------
  // all architectural effects land on the first cycle; the second only holds off the bus
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ccdo_pkg::ccdo_run;
    end else begin
      case (state)
        ccdo_pkg::ccdo_run: begin
          if (cmd_go && two_cycle) begin
            state <= ccdo_pkg::ccdo_second; // RULE2 RULE9
          end
        end
        ccdo_pkg::ccdo_second: begin
          state <= ccdo_pkg::ccdo_run;
        end
        default: begin
          state <= ccdo_pkg::ccdo_run;
        end
      endcase
    end
  end

  // ----------------------------------------
  // program counter and return stack
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc <= `CCDO_RST_PC;
    end else if (cmd_go) begin
      case (op)
        `CCDO_OP_CALL:    pc <= {program_page_latch[6:3], k_lit}; // RULE1
        `CCDO_OP_CALL_IND: pc <= {program_page_latch, wreg}; // RULE3
        `CCDO_OP_DECSKIP: pc <= two_cycle ? pc + 15'h0002 : ret_addr; // RULE9
        default:          pc <= ret_addr;
      endcase
    end else if (wr_en && addr_is(paddr, `CCDO_OFF_PC)) begin
      pc <= pwdata[14:0];
    end
  end

  // overflow simply wraps; nothing in the core resets the pointer on overflow
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stack_ptr <= 4'h0;
    end else if (cmd_go && is_call(op)) begin
      stack_ptr <= stack_ptr + 4'h1; // RULE1 RULE3
    end
  end

  always_ff @(posedge pclk) begin
    if (cmd_go && is_call(op)) begin
      return_stack[stack_ptr] <= ret_addr; // RULE1 RULE3
    end
  end

  // ----------------------------------------
  // working register, page latch, file
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wreg <= `CCDO_RST_WREG;
    end else if (cmd_go && res_to_w) begin
      wreg <= result; // RULE5 RULE7 RULE8 RULE9
    end else if (wr_en && addr_is(paddr, `CCDO_OFF_WREG)) begin
      wreg <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      program_page_latch <= `CCDO_RST_PAGE;
    end else if (wr_en && addr_is(paddr, `CCDO_OFF_PAGE)) begin
      program_page_latch <= pwdata[6:0];
    end
  end

  always_ff @(posedge pclk) begin
    if (cmd_go && res_to_file) begin
      file_mem[f_addr] <= result; // RULE5 RULE6 RULE7 RULE9
    end else if (wr_en && file_hit(paddr)) begin
      file_mem[paddr[8:2]] <= pwdata[7:0];
    end
  end

  // ----------------------------------------
  // status flags
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      zero_flag <= 1'b0;
    end else if (cmd_go && upd_zero) begin
      zero_flag <= (result == 8'h00); // RULE10 RULE6 RULE8
    end
  end

  // ----------------------------------------
  // watchdog counter
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      watchdog_prescaler <= 8'h00;
      watchdog_counter   <= 16'h0000;
      timeout_flag       <= 1'b1;
      power_down_flag    <= 1'b1;
    end else if (cmd_go && op == `CCDO_OP_WDCLR) begin
      watchdog_prescaler <= 8'h00; // RULE4
      watchdog_counter   <= 16'h0000;
      timeout_flag       <= 1'b1;
      power_down_flag    <= 1'b1;
    end else begin
      watchdog_prescaler <= watchdog_prescaler + 8'h01;
      if (watchdog_prescaler == 8'hFF) begin
        watchdog_counter <= watchdog_counter + 16'h0001;
        // flag is active low: a wrap marks a timeout
        if (watchdog_counter == 16'hFFFF) begin
          timeout_flag <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------
  // apb read data, captured in the setup cycle
  // ----------------------------------------
  always_comb begin
    next_prdata = 32'h0000_0000;
    if (file_hit(paddr)) begin
      next_prdata = {24'h00_0000, file_mem[paddr[8:2]]};
    end else if (addr_is(paddr, `CCDO_OFF_WREG)) begin
      next_prdata = {24'h00_0000, wreg};
    end else if (addr_is(paddr, `CCDO_OFF_PC)) begin
      next_prdata = {17'h0_0000, pc};
    end else if (addr_is(paddr, `CCDO_OFF_PAGE)) begin
      next_prdata = {25'h000_0000, program_page_latch};
    end else if (addr_is(paddr, `CCDO_OFF_STATUS)) begin
      next_prdata = {28'h000_0000, busy, power_down_flag, timeout_flag, zero_flag};
    end else if (addr_is(paddr, `CCDO_OFF_STACK)) begin
      next_prdata = {12'h000, stack_ptr, 1'b0, return_stack[stack_ptr - 4'h1]};
    end else if (addr_is(paddr, `CCDO_OFF_WDOG)) begin
      next_prdata = {8'h00, watchdog_prescaler, watchdog_counter};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= next_prdata;
    end
  end

endmodule

/* File: ccdo_cfg.svh */
// Summary of operation
// RULE1: call pushes return, loads page-latched target
// RULE2: absolute call two cycles, flags untouched
// RULE3: indirect call uses working register, page latch
// RULE4: watchdog clear zeroes counter, sets flags
// RULE5: complement file, destination bit, zero flag
// RULE6: clear file register, zero flag set
// RULE7: decrement file, destination bit, zero flag
// RULE8: clear working register, zero flag set
// RULE9: decrement skip on zero, two cycles, flagless
// RULE10: zero flag follows eight-bit result
`ifndef CCDO_CFG_SVH
`define CCDO_CFG_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define CCDO_OFF_CMD       12'h000
`define CCDO_OFF_WREG      12'h004
`define CCDO_OFF_PC        12'h008
`define CCDO_OFF_PAGE      12'h00C
`define CCDO_OFF_STATUS    12'h010
`define CCDO_OFF_STACK     12'h014
`define CCDO_OFF_WDOG      12'h018
`define CCDO_FILE_BASE_HI  3'h1

// ----------------------------------------
// command word fields
// ----------------------------------------
`define CCDO_CMD_OP_HI     3
`define CCDO_CMD_DEST_BIT  7
`define CCDO_CMD_F_LO      8
`define CCDO_CMD_F_HI      14
`define CCDO_CMD_K_LO      16
`define CCDO_CMD_K_HI      26

// ----------------------------------------
// opcodes
// ----------------------------------------
`define CCDO_OP_NOP        4'h0
`define CCDO_OP_CALL       4'h1
`define CCDO_OP_CALL_IND   4'h2
`define CCDO_OP_WDCLR      4'h3
`define CCDO_OP_COMP_FILE  4'h4
`define CCDO_OP_CLR_FILE   4'h5
`define CCDO_OP_DEC_FILE   4'h6
`define CCDO_OP_CLR_W      4'h7
`define CCDO_OP_DECSKIP    4'h8

// ----------------------------------------
// reset values and array depths
// ----------------------------------------
`define CCDO_RST_PC        15'h0000
`define CCDO_RST_WREG      8'h00
`define CCDO_RST_PAGE      7'h00
`define CCDO_STACK_DEPTH   16
`define CCDO_FILE_DEPTH    128

`endif

/* File: ccdo_pkg.sv */
package ccdo_pkg;

  typedef enum logic {
    ccdo_run,
    ccdo_second
  } ccdo_state_e;

  typedef logic [3:0] ccdo_op_t;

endpackage

/* File: ccdo_core_asserts.sv */
`timescale 1ns/1ps
`include "ccdo_cfg.svh"

module ccdo_core_asserts (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // request
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  // answer
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // ----------------
  // command steps
  // ----------------
  sequence s_cmd(logic [3:0] op);
    psel && penable && pready && pwrite && paddr == `CCDO_OFF_CMD && pwdata[3:0] == op;
  endsequence
  // status read set up right after the command lands, so no other op can touch the flags
  sequence s_stat;
    psel && !penable && !pwrite && paddr == `CCDO_OFF_STATUS;
  endsequence

  chk_call_stall:
    assert property (s_cmd(`CCDO_OP_CALL) |=> !pready ##1 pready) else $error("call stall wrong");
  chk_indirect_stall:
    assert property (s_cmd(`CCDO_OP_CALL_IND) |=> !pready ##1 pready)
      else $error("indirect call stall wrong");
  chk_comp_single:
    assert property (s_cmd(`CCDO_OP_COMP_FILE) |=> pready) else $error("complement stalled");
  chk_dec_single:
    assert property (s_cmd(`CCDO_OP_DEC_FILE) |=> pready) else $error("decrement stalled");
  chk_stall_once:
    assert property ($fell(pready) |=> pready) else $error("stall longer than one cycle");
  chk_wdclr_flags:
    assert property (s_cmd(`CCDO_OP_WDCLR) ##1 s_stat |=> prdata[2:1] == 2'b11)
      else $error("wake flags not set");
  chk_clr_file_zero:
    assert property (s_cmd(`CCDO_OP_CLR_FILE) ##1 s_stat |=> prdata[0])
      else $error("zero not set");
  chk_clr_w_zero:
    assert property (s_cmd(`CCDO_OP_CLR_W) ##1 s_stat |=> prdata[0]) else $error("zero not set");
endmodule

bind ccdo_core ccdo_core_asserts i_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr);

/* File: testbench.sv */
`timescale 1ns/1ps
`include "ccdo_cfg.svh"

module testbench;
  typedef struct packed {
    logic [3:0]  op;
    logic        d;
    logic [7:0]  init;
    logic [7:0]  res;
    logic        zp;
    logic        z;
    logic [14:0] pc;
  } ccdo_row_s;

  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [31:0] rdat;
  logic        rerr;
  int          fails = 0;
  int          samples_checked = 0;
  ccdo_row_s   rows [8];

  always #25 pclk = ~pclk;

  ccdo_core i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr);

  // ----------------
  // bus helpers
  // ----------------
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // entered just after a rising edge; psel stays high so transfers run back to back
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // answer read at the edge, before that edge's own updates land
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      fails++;
      tally_and_finish();
    end
    rdat = prdata;
    rerr = pslverr;
  endtask

  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0000_0000);
  endtask

  task automatic ex(input logic [3:0] op, input logic d, input logic [6:0] f,
                    input logic [10:0] k);
    apb(1'b1, `CCDO_OFF_CMD, {5'h00, k, 1'b0, f, d, 3'h0, op});
  endtask

  task automatic idle();
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // ----------------
  // sequence
  // ----------------
  initial begin
    rows = '{
      '{`CCDO_OP_COMP_FILE, 1'b0, 8'h0f, 8'hf0, 1'b1, 1'b0, 15'h0101},
      '{`CCDO_OP_COMP_FILE, 1'b1, 8'hff, 8'h00, 1'b0, 1'b1, 15'h0101},
      '{`CCDO_OP_DEC_FILE, 1'b0, 8'h00, 8'hff, 1'b1, 1'b0, 15'h0101},
      '{`CCDO_OP_DEC_FILE, 1'b1, 8'h01, 8'h00, 1'b0, 1'b1, 15'h0101},
      '{`CCDO_OP_DECSKIP, 1'b0, 8'h01, 8'h00, 1'b0, 1'b0, 15'h0102},
      '{`CCDO_OP_DECSKIP, 1'b1, 8'h03, 8'h02, 1'b1, 1'b1, 15'h0101},
      '{`CCDO_OP_CLR_FILE, 1'b1, 8'ha5, 8'h00, 1'b0, 1'b1, 15'h0101},
      '{`CCDO_OP_CLR_W, 1'b0, 8'ha5, 8'h00, 1'b0, 1'b1, 15'h0101}};
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // files 10 and 11 prime the zero flag to 0 or 1 through a complement into W
    apb(1'b1, 12'h228, 32'h0000_0000);
    apb(1'b1, 12'h22c, 32'h0000_00ff);
    foreach (rows[i]) begin
      apb(1'b1, 12'h214, {24'h00_0000, rows[i].init});
      ex(`CCDO_OP_COMP_FILE, 1'b0, rows[i].zp ? 7'h0b : 7'h0a, 11'h000);
      apb(1'b1, `CCDO_OFF_WREG, 32'h0000_005a);
      apb(1'b1, `CCDO_OFF_PC, 32'h0000_0100);
      ex(rows[i].op, rows[i].d, 7'h05, 11'h000);
      rd(`CCDO_OFF_STATUS);
      chk("zero flag", rows[i].z, rdat[0]);
      rd(`CCDO_OFF_WREG);
      chk("working register", rows[i].d ? 8'h5a : rows[i].res, rdat);
      rd(12'h214);
      chk("file register", rows[i].d ? rows[i].res : rows[i].init, rdat);
      rd(`CCDO_OFF_PC);
      chk("program counter", rows[i].pc, rdat);
    end
    ex(`CCDO_OP_COMP_FILE, 1'b0, 7'h0b, 11'h000);
    apb(1'b1, `CCDO_OFF_WREG, 32'h0000_00c3);
    apb(1'b1, `CCDO_OFF_PAGE, 32'h0000_0055);
    apb(1'b1, `CCDO_OFF_PC, 32'h0000_0123);
    ex(`CCDO_OP_CALL, 1'b0, 7'h00, 11'h7ff);
    rd(`CCDO_OFF_PC);
    chk("call target", 32'h0000_57ff, rdat);
    rd(`CCDO_OFF_STACK);
    chk("call return", 32'h0001_0124, rdat);
    ex(`CCDO_OP_CALL_IND, 1'b0, 7'h00, 11'h000);
    rd(`CCDO_OFF_PC);
    chk("indirect target", 32'h0000_55c3, rdat);
    rd(`CCDO_OFF_STACK);
    chk("indirect return", 32'h0002_5800, rdat);
    rd(`CCDO_OFF_STATUS);
    chk("flags after calls", 1'b1, rdat[0]);
    idle();
    repeat (600) @(posedge pclk);
    ex(`CCDO_OP_WDCLR, 1'b0, 7'h00, 11'h000);
    rd(`CCDO_OFF_STATUS);
    chk("flags after watchdog clear", 32'h0000_0007, rdat);
    rd(`CCDO_OFF_WDOG);
    // prescaler restarts at zero, then counts the two clocks of the status read
    chk("watchdog count", 32'h0002_0000, rdat);
    rd(12'h100);
    chk("error response", 1'b1, rerr);
    idle();
    presetn <= 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(`CCDO_OFF_STATUS);
    chk("status at reset", 32'h0000_0006, rdat);
    rd(`CCDO_OFF_PC);
    chk("pc at reset", 32'h0000_0000, rdat);
    idle();
    tally_and_finish();
  end
endmodule
